// [logic/bps_parity_status.sv]
`timescale 1ns/1ps

// Function
// [R1] The secondary detected-parity bit is set on a secondary-bus parity error regardless of either response enable.
// [R2] The secondary detected-parity bit is set only for downstream reads, upstream posted writes or upstream delayed writes seen on the secondary bus.
// [R3] The primary master data-parity bit is set only while the bridge is master on the primary bus.
// [R4] The primary master data-parity bit is set only when the primary response enable is one.
// [R5] As primary master, the primary parity-error pin asserted or an own primary-bus detection triggers the primary master data-parity bit.
// [R6] The primary master data-parity bit is set for primary-bus errors in upstream reads, posted writes and delayed writes, ignoring the secondary enable.
// [R7] The secondary master data-parity bit is set only while the bridge is master on the secondary bus.
// [R8] The secondary master data-parity bit is set only when the secondary response enable is one.
// [R9] As secondary master, the secondary parity-error pin asserted or an own secondary-bus detection triggers the secondary master data-parity bit.
// [R10] The secondary master data-parity bit is set for secondary-bus errors in downstream reads, posted writes and delayed writes, ignoring the primary enable.
// [R11] The primary detected-parity bit is set for primary-bus errors in upstream reads, downstream posted writes and downstream delayed writes, independent of both enables.
// [R12] Each status bit stays set until software writes a one to it or reset clears it, and a set beats a clear.
module bps_parity_status
	import bps_pkg::*;
(
	// Clock, reset and enable.
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	input  wire logic       clk_en,
	// Transaction context.
	input  wire logic [1:0] trans_type,
	input  wire logic       trans_dir,
	// Parity errors detected by the bridge itself.
	input  wire logic       pri_parity_det,
	input  wire logic       sec_parity_det,
	// Bridge is master on each bus.
	input  wire logic       pri_master,
	input  wire logic       sec_master,
	// Parity-error pins as sampled, active low.
	input  wire logic       primary_parity_err_pin,
	input  wire logic       secondary_parity_err_pin,
	// Response enables.
	input  wire logic       pri_perr_resp_en,
	input  wire logic       sec_perr_resp_en,
	// Write-one-to-clear strobes.
	input  wire logic       clr_pri_det,
	input  wire logic       clr_sec_det,
	input  wire logic       clr_pri_mdp,
	input  wire logic       clr_sec_mdp,
	// Status bits.
	output logic            pri_det_parity,
	output logic            sec_det_parity,
	output logic            pri_master_dpar,
	output logic            sec_master_dpar
);

	logic set_pri_det;
	logic set_sec_det;
	logic set_pri_mdp;
	logic set_sec_mdp;
	logic is_read;
	logic is_write;
	logic pri_pin_seen;
	logic sec_pin_seen;

	assign is_read      = (trans_type == BPS_TT_READ);
	assign is_write     = (trans_type == BPS_TT_POSTED) || (trans_type == BPS_TT_DELAYED);
	assign pri_pin_seen = (primary_parity_err_pin == BPS_PIN_ASSERTED);
	assign sec_pin_seen = (secondary_parity_err_pin == BPS_PIN_ASSERTED);

	// Primary detected bit, enables ignored.
	// [R11] upstream read or downstream write
	assign set_pri_det = pri_parity_det &&
		((is_read && trans_dir == BPS_DIR_UP) || (is_write && trans_dir == BPS_DIR_DOWN));

	// [R1] no enable in the term
	// [R2] secondary bus combinations
	assign set_sec_det = sec_parity_det &&
		((is_read && trans_dir == BPS_DIR_DOWN) || (is_write && trans_dir == BPS_DIR_UP));

	// The master bits cover every traffic type the bridge masters on that bus; the
	// direction is implied by which bus the bridge masters, and it is checked anyway.
	// [R3] primary master only
	// [R4] primary enable gate
	// [R5] pin or own detection
	// [R6] upstream only
	assign set_pri_mdp = pri_master && pri_perr_resp_en &&
		(pri_pin_seen || pri_parity_det) &&
		(is_read || is_write) && (trans_dir == BPS_DIR_UP);

	// [R7] secondary master only
	// [R8] secondary enable gate
	// [R9] pin or own detection
	// [R10] downstream only
	assign set_sec_mdp = sec_master && sec_perr_resp_en &&
		(sec_pin_seen || sec_parity_det) &&
		(is_read || is_write) && (trans_dir == BPS_DIR_DOWN);

	// Sticky update: a set in the same cycle as a clear wins, so no event is lost.
	function automatic logic sticky(input logic cur, input logic set, input logic clr);
		sticky = set | (cur & ~clr);
	endfunction

	// [R12] sticky primary detected
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
			pri_det_parity <= BPS_STAT_RESET;
		else if (clk_en)
			pri_det_parity <= sticky(pri_det_parity, set_pri_det, clr_pri_det);
	end

	// [R12] sticky secondary detected
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
			sec_det_parity <= BPS_STAT_RESET;
		else if (clk_en)
			sec_det_parity <= sticky(sec_det_parity, set_sec_det, clr_sec_det);
	end

	// [R12] sticky primary master
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
			pri_master_dpar <= BPS_STAT_RESET;
		else if (clk_en)
			pri_master_dpar <= sticky(pri_master_dpar, set_pri_mdp, clr_pri_mdp);
	end

	// [R12] sticky secondary master
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
			sec_master_dpar <= BPS_STAT_RESET;
		else if (clk_en)
			sec_master_dpar <= sticky(sec_master_dpar, set_sec_mdp, clr_sec_mdp);
	end

	// Assertions.
	sequence sec_err_s;
		clk_en && sec_parity_det && is_read && trans_dir == BPS_DIR_DOWN;
	endsequence

	sequence pri_mst_err_s;
		clk_en && pri_master && pri_perr_resp_en && pri_pin_seen && is_write &&
			trans_dir == BPS_DIR_UP;
	endsequence

	sequence sec_wr_err_s;
		clk_en && sec_parity_det && is_write && trans_dir == BPS_DIR_UP;
	endsequence

	sequence pri_rd_err_s;
		clk_en && pri_parity_det && is_read && trans_dir == BPS_DIR_UP;
	endsequence

	sequence sec_mst_err_s;
		clk_en && sec_master && sec_perr_resp_en && sec_pin_seen && is_write &&
			trans_dir == BPS_DIR_DOWN;
	endsequence

	sec_det_any_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R1]
		sec_err_s |=> sec_det_parity)
		else $error("secondary detected bit not set on secondary error");

	sec_det_only_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R2]
		(clk_en && !sec_det_parity && (!sec_parity_det || trans_type == BPS_TT_NONE ||
			(is_read && trans_dir == BPS_DIR_UP) ||
			(is_write && trans_dir == BPS_DIR_DOWN))) |=> !sec_det_parity)
		else $error("secondary detected bit set without cause");

	sec_det_wr_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R2]
		sec_wr_err_s |=> sec_det_parity)
		else $error("secondary detected bit not set on upstream write");

	sec_det_noen_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R1]
		(clk_en && sec_parity_det && is_read && trans_dir == BPS_DIR_DOWN &&
			!pri_perr_resp_en && !sec_perr_resp_en) |=> sec_det_parity)
		else $error("secondary detected bit waited for an enable");

	pri_mst_only_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R3]
		(clk_en && !pri_master && !pri_master_dpar) |=> !pri_master_dpar)
		else $error("primary master bit set while not master");

	pri_mst_en_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R4]
		(clk_en && !pri_perr_resp_en && !pri_master_dpar) |=> !pri_master_dpar)
		else $error("primary master bit set with enable low");

	pri_mst_pin_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R5]
		pri_mst_err_s |=> pri_master_dpar)
		else $error("primary master bit missed pin report");

	pri_mst_dir_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R6]
		(clk_en && trans_dir == BPS_DIR_DOWN && !pri_master_dpar) |=> !pri_master_dpar)
		else $error("primary master bit set on downstream");

	sec_mst_only_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R7]
		(clk_en && !sec_master && !sec_master_dpar) |=> !sec_master_dpar)
		else $error("secondary master bit set while not master");

	sec_mst_en_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R8]
		(clk_en && !sec_perr_resp_en && !sec_master_dpar) |=> !sec_master_dpar)
		else $error("secondary master bit set with enable low");

	sec_mst_trig_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R9]
		(clk_en && sec_master && sec_perr_resp_en && (sec_pin_seen || sec_parity_det) &&
			is_read && trans_dir == BPS_DIR_DOWN) |=> sec_master_dpar)
		else $error("secondary master bit missed trigger");

	sec_mst_dir_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R10]
		(clk_en && trans_dir == BPS_DIR_UP && !sec_master_dpar) |=> !sec_master_dpar)
		else $error("secondary master bit set on upstream");

	pri_det_set_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R11]
		(clk_en && pri_parity_det && is_write && trans_dir == BPS_DIR_DOWN)
			|=> pri_det_parity)
		else $error("primary detected bit not set on downstream write");

	sticky_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R12]
		(pri_det_parity && (!clk_en || !clr_pri_det)) |=> pri_det_parity [*1])
		else $error("primary detected bit dropped without clear");

	sticky_clr_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R12]
		(clk_en && clr_sec_det && !sec_parity_det) |=> !sec_det_parity)
		else $error("secondary detected bit not cleared");

	pri_det_read_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R11]
		pri_rd_err_s |=> pri_det_parity)
		else $error("primary detected bit not set on upstream read");

	pri_det_only_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R11]
		(clk_en && !pri_det_parity && (!pri_parity_det || trans_type == BPS_TT_NONE ||
			(is_read && trans_dir == BPS_DIR_DOWN) ||
			(is_write && trans_dir == BPS_DIR_UP))) |=> !pri_det_parity)
		else $error("primary detected bit set without cause");

	pri_mst_own_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R5]
		(clk_en && pri_master && pri_perr_resp_en && pri_parity_det && !pri_pin_seen &&
			is_read && trans_dir == BPS_DIR_UP) |=> pri_master_dpar)
		else $error("primary master bit missed own detection");

	pri_mst_cause_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R5]
		(clk_en && !pri_master_dpar && !pri_parity_det && !pri_pin_seen)
			|=> !pri_master_dpar)
		else $error("primary master bit set with no trigger");

	// The secondary enable is held low here to show that it plays no part.
	pri_mst_sec_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R6]
		(clk_en && pri_master && pri_perr_resp_en && !sec_perr_resp_en && pri_parity_det &&
			is_write && trans_dir == BPS_DIR_UP) |=> pri_master_dpar)
		else $error("primary master bit depends on secondary enable");

	pri_mst_none_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R6]
		(clk_en && trans_type == BPS_TT_NONE && !pri_master_dpar) |=> !pri_master_dpar)
		else $error("primary master bit set with no transaction");

	sec_mst_pin_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R9]
		sec_mst_err_s |=> sec_master_dpar)
		else $error("secondary master bit missed pin report");

	sec_mst_cause_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R9]
		(clk_en && !sec_master_dpar && !sec_parity_det && !sec_pin_seen)
			|=> !sec_master_dpar)
		else $error("secondary master bit set with no trigger");

	// The primary enable is held low here to show that it plays no part.
	sec_mst_pri_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R10]
		(clk_en && sec_master && sec_perr_resp_en && !pri_perr_resp_en && sec_parity_det &&
			is_write && trans_dir == BPS_DIR_DOWN) |=> sec_master_dpar)
		else $error("secondary master bit depends on primary enable");

	sec_mst_none_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R10]
		(clk_en && trans_type == BPS_TT_NONE && !sec_master_dpar) |=> !sec_master_dpar)
		else $error("secondary master bit set with no transaction");

	// A clear that meets a new event must not lose the event.
	set_wins_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R12]
		pri_mst_err_s ##0 clr_pri_mdp |=> pri_master_dpar)
		else $error("clear beat a primary master set");

	set_wins_sd_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R12]
		sec_wr_err_s ##0 clr_sec_det |=> sec_det_parity)
		else $error("clear beat a secondary detected set");

	hold_sd_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R12]
		(sec_det_parity && (!clk_en || !clr_sec_det)) |=> sec_det_parity)
		else $error("secondary detected bit dropped without clear");

	hold_pm_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R12]
		(pri_master_dpar && (!clk_en || !clr_pri_mdp)) |=> pri_master_dpar)
		else $error("primary master bit dropped without clear");

	hold_sm_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R12]
		(sec_master_dpar && (!clk_en || !clr_sec_mdp)) |=> sec_master_dpar)
		else $error("secondary master bit dropped without clear");

	clr_pd_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R12]
		(clk_en && clr_pri_det && !pri_parity_det) |=> !pri_det_parity)
		else $error("primary detected bit not cleared");

	clr_pm_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R12]
		(clk_en && clr_pri_mdp && !pri_master) |=> !pri_master_dpar)
		else $error("primary master bit not cleared");

	clr_sm_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R12]
		(clk_en && clr_sec_mdp && !sec_master) |=> !sec_master_dpar)
		else $error("secondary master bit not cleared");

	// A low clock enable must also hold off clears, or software could lose an event.
	stat_freeze_a: assert property (@(posedge core_clk) disable iff (!rst_b) // [R12]
		!clk_en |=> ($stable(pri_det_parity) && $stable(sec_det_parity) &&
			$stable(pri_master_dpar) && $stable(sec_master_dpar)))
		else $error("status bit changed while clock enable low");

	rst_clear_a: assert property (@(posedge core_clk) // [R12]
		!rst_b |=> (!pri_det_parity && !sec_det_parity &&
			!pri_master_dpar && !sec_master_dpar))
		else $error("status bit survived reset");

endmodule

// [logic/bps_pkg.sv]
package bps_pkg;

	// Transaction type codes.
	typedef enum logic [1:0]
	{
		BPS_TT_READ    = 2'b00,
		BPS_TT_POSTED  = 2'b01,
		BPS_TT_DELAYED = 2'b10,
		BPS_TT_NONE    = 2'b11
	} bps_ttype_t;

	// Direction codes.
	localparam logic BPS_DIR_DOWN = 1'b0;
	localparam logic BPS_DIR_UP   = 1'b1;

	// Bus where an error was seen.
	localparam logic BPS_BUS_PRI = 1'b0;
	localparam logic BPS_BUS_SEC = 1'b1;

	// Reset value of every status bit.
	localparam logic BPS_STAT_RESET = 1'b0;

	// Active level of the parity-error pins (low true).
	localparam logic BPS_PIN_ASSERTED = 1'b0;

endpackage

// [testbench/bps_pci_agent.sv]
`timescale 1ns/1ps

module bps_pci_agent
	import bps_pkg::*;
(
	// Error reports requested by the bench.
	input  wire logic pri_err_req,
	input  wire logic sec_err_req,
	// Sampled parity-error pins.
	output logic      primary_parity_err_pin,
	output logic      secondary_parity_err_pin
);
	// Released pins sit at the pull-up level, so a stale low can never linger.
	assign primary_parity_err_pin   = pri_err_req ? BPS_PIN_ASSERTED : ~BPS_PIN_ASSERTED;
	assign secondary_parity_err_pin = sec_err_req ? BPS_PIN_ASSERTED : ~BPS_PIN_ASSERTED;
endmodule

// [testbench/bridge_parity_status_logic_tb.sv]
`timescale 1ns/1ps

module bridge_parity_status_logic_tb
	import bps_pkg::*;
;
	logic       core_clk, rst_b, clk_en, trans_dir, pri_parity_det, sec_parity_det;
	logic       pri_master, sec_master, pri_err_req, sec_err_req;
	logic       pri_perr_resp_en, sec_perr_resp_en;
	logic [1:0] trans_type;
	logic [3:0] clr, exp_st;
	wire logic  p_pin, s_pin, o_pd, o_sd, o_pm, o_sm;
	int         fail_count, checked;

	bps_pci_agent u_agent (.pri_err_req(pri_err_req), .sec_err_req(sec_err_req),
		.primary_parity_err_pin(p_pin), .secondary_parity_err_pin(s_pin));

	bps_parity_status DUT (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
		.trans_type(trans_type), .trans_dir(trans_dir), .pri_parity_det(pri_parity_det),
		.sec_parity_det(sec_parity_det), .pri_master(pri_master), .sec_master(sec_master),
		.primary_parity_err_pin(p_pin), .secondary_parity_err_pin(s_pin),
		.pri_perr_resp_en(pri_perr_resp_en), .sec_perr_resp_en(sec_perr_resp_en),
		.clr_pri_det(clr[0]), .clr_sec_det(clr[1]), .clr_pri_mdp(clr[2]), .clr_sec_mdp(clr[3]),
		.pri_det_parity(o_pd), .sec_det_parity(o_sd), .pri_master_dpar(o_pm),
		.sec_master_dpar(o_sm));

	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	task automatic chk(input logic seen, input logic exp);
		checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t status bit %b, model %b", $time, seen, exp);
		end
	endtask

	task automatic step();
		logic       rd, wr, up;
		logic [3:0] set;
		{trans_type, trans_dir, pri_parity_det, sec_parity_det, pri_master, sec_master,
			pri_err_req, sec_err_req, pri_perr_resp_en, sec_perr_resp_en} = 11'($urandom);
		clk_en = ($urandom % 8) != 0;
		clr = 4'($urandom & $urandom & $urandom);
		// The agent's pins follow the requests through a continuous assign; wait before reading.
		#1;
		rd = trans_type == 2'h0;
		wr = trans_type == 2'h1 || trans_type == 2'h2;
		up = trans_dir == BPS_DIR_UP;
		set[0] = pri_parity_det & ((rd & up) | (wr & ~up));
		set[1] = sec_parity_det & ((rd & ~up) | (wr & up));
		set[2] = pri_master & pri_perr_resp_en & ((p_pin === BPS_PIN_ASSERTED) | pri_parity_det)
			& (rd | wr) & up;
		set[3] = sec_master & sec_perr_resp_en & ((s_pin === BPS_PIN_ASSERTED) | sec_parity_det)
			& (rd | wr) & ~up;
		if (!rst_b)
			exp_st = 4'h0;
		else if (clk_en)
			exp_st = set | (exp_st & ~clr);
		@(posedge core_clk);
		#1;
		chk(o_pd, exp_st[0]);
		chk(o_sd, exp_st[1]);
		chk(o_pm, exp_st[2]);
		chk(o_sm, exp_st[3]);
	endtask

	task print_verdict;
		$display("checked %0d, fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		#100000;
		fail_count++;
		print_verdict;
	end

	initial
	begin
		rst_b = 1'b0;
		clk_en = 1'b1;
		clr = 4'h0;
		exp_st = 4'h0;
		{trans_type, trans_dir, pri_parity_det, sec_parity_det, pri_master, sec_master,
			pri_err_req, sec_err_req, pri_perr_resp_en, sec_perr_resp_en} = 11'h0;
		void'($urandom(81));
		repeat (16) @(posedge core_clk);
		#1 rst_b = 1'b1;
		repeat (4000) step();
		$display("random traffic test done");
		// A second reset in mid-run must drop every sticky bit.
		rst_b = 1'b0;
		repeat (2) step();
		rst_b = 1'b1;
		repeat (200) step();
		$display("mid-run reset test done");
		print_verdict;
	end
endmodule
